// ==== design/lin_err_defs.svh ====
// constants for the error interrupt enable set/clear block
`ifndef LIN_ERR_DEFS_SVH
`define LIN_ERR_DEFS_SVH

// ======================================================
// register byte offsets
`define OFS_ENABLE_SET    8'h00
`define OFS_ENABLE_CLEAR  8'h04
`define OFS_MODE_CTRL     8'h08
`define OFS_ERR_STATUS    8'h0c
`define OFS_ERR_MASK      8'h10

// ======================================================
// field positions
`define ERR_FIELD_LSB     24
`define ERR_FIELD_MSB     31
`define ERR_COUNT         8
`define LIN_ONLY_LSB      3
`define MODE_LIN_BIT      0

// ======================================================
// reset values
`define RST_ENABLE        1'b0
`define RST_STATUS        1'b0
`define RST_MASK          8'h00
`define RST_LIN_MODE      1'b0
`define RST_RDATA         32'h0000_0000

`endif

// ==== design/lin_err_pkg.sv ====
// types shared by the error interrupt enable block
package lin_err_pkg;

   // ======================================================
   // bus answer states
   typedef enum logic {
      BUS_IDLE,
      BUS_ACK
   } bus_state_t;

   // ======================================================
   // per-error cell state
   typedef struct packed {
      logic enable;            // interrupt enable of this error
      logic status;            // sticky event flag
   } cell_state_t;

   // ======================================================
   // bus slave and control state of the top module
   typedef struct packed {
      bus_state_t  st;         // answer phase
      logic        wait_req;   // waitrequest toward the master
      logic [31:0] rdata;      // captured read word
      logic        lin_mode;   // lin mode when set, sci mode when clear
      logic [7:0]  mask;       // interrupt mask, same layout as status
      logic        irq;        // registered interrupt level
   } slave_state_t;

endpackage : lin_err_pkg

// ==== design/error_enable_cell.sv ====
// one error source: enable flip-flop and sticky status flag
`timescale 1ns/1ps
`include "lin_err_defs.svh"
module error_enable_cell
   import lin_err_pkg::*;
(
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic i_set_enable,    // one-cycle set of the enable
   input  wire logic i_clear_enable,  // one-cycle clear of the enable
   input  wire logic i_event,         // error pulse from the protocol engine
   input  wire logic i_status_clear,  // write-one-to-clear of the flag
   output logic      o_enable,        // enable level
   output logic      o_status         // sticky flag level
);

   cell_state_t s_q;                  // registered state
   cell_state_t s_d;                  // next state

   // ======================================================
   // next state
   always_comb
   begin
      s_d = s_q;
      // clear is applied after set so it wins on a collision
      s_d.enable = (s_q.enable | i_set_enable) & ~i_clear_enable;
      // a new event beats a software clear in the same cycle
      s_d.status = (s_q.status & ~i_status_clear) | (i_event & s_q.enable);
   end

   // ======================================================
   // state register
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q.enable <= `RST_ENABLE;
         s_q.status <= `RST_STATUS;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_enable = s_q.enable;
   assign o_status = s_q.status;

endmodule : error_enable_cell

// ==== design/lin_error_interrupt_enable_clear.sv ====
// error interrupt enable set/clear registers with avalon-mm slave
`timescale 1ns/1ps
`include "lin_err_defs.svh"
module lin_error_interrupt_enable_clear
   import lin_err_pkg::*;
(
   input  wire logic        i_sys_clk,          // module clock, 200 mhz
   input  wire logic        i_rst_n,            // asynchronous reset, active low
   input  wire logic [7:0]  i_avs_address,      // byte address
   input  wire logic        i_avs_read,         // read request
   input  wire logic        i_avs_write,        // write request
   input  wire logic [31:0] i_avs_writedata,    // write data
   input  wire logic [3:0]  i_avs_byteenable,   // byte lanes of a write
   input  wire logic [7:0]  i_error_event,      // error pulses, bit n is field 24+n
   output logic [31:0]      o_avs_readdata,     // read data
   output logic             o_avs_waitrequest,  // stall toward the master
   output logic [7:0]       o_error_enable,     // enables toward the engine
   output logic             o_lin_mode,         // current operating mode
   output logic             o_irq               // level interrupt
);

   // ======================================================
   // local signals
   slave_state_t s_q;                 // registered slave state
   slave_state_t s_d;                 // next slave state
   logic [7:0]   enable_w;            // enables from the cells
   logic [7:0]   status_w;            // sticky flags from the cells
   logic [7:0]   set_pulse;           // set strobes toward the cells
   logic [7:0]   clr_pulse;           // clear strobes toward the cells
   logic [7:0]   status_clr;          // flag clear strobes
   logic [31:0]  wmask;               // write data gated by byte lanes
   logic [7:0]   field_wr;            // the eight error fields of the write
   logic [7:0]   field_allow;         // fields writable in the current mode
   logic         wr_commit;           // write takes effect this edge
   logic [31:0]  rd_word;             // word presented for a read

   // ======================================================
   // address match, shared by read and write decode
   function automatic logic reg_hit
   (
      input logic [7:0] addr,
      input logic [7:0] ofs
   );
      reg_hit = (addr == ofs);
   endfunction : reg_hit

   // ======================================================
   // expand byte enables into a bit mask
   function automatic logic [31:0] lane_mask
   (
      input logic [3:0] be
   );
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // ======================================================
   // place eight error bits in their word position
   function automatic logic [31:0] err_word
   (
      input logic [7:0] bits
   );
      // bits 23 to 0 stay zero, covering the reserved field
      err_word = {bits, 24'h00_0000};
   endfunction : err_word

   // ======================================================
   // write field extraction
   always_comb
   begin
      wmask    = i_avs_writedata & lane_mask(i_avs_byteenable);
      // only bits 31..24 are taken; 23..14 and below are dropped
      field_wr = wmask[`ERR_FIELD_MSB:`ERR_FIELD_LSB];
   end

   // ======================================================
   // mode gating of the lin-only fields
   always_comb
   begin
      // parity, overrun and framing act in both modes
      field_allow = 8'hff;
      if (!s_q.lin_mode)
      begin
         // bits 31..27 are lin-only; an sci-mode write is dropped
         field_allow[7:`LIN_ONLY_LSB] = 5'h00;
      end
   end

   // the write happens at the edge where waitrequest is seen low
   assign wr_commit = (s_q.st == BUS_ACK) && i_avs_write;

   // ======================================================
   // strobes toward the enable cells
   always_comb
   begin
      set_pulse  = 8'h00;
      clr_pulse  = 8'h00;
      status_clr = 8'h00;
      if (wr_commit)
      begin
         if (reg_hit(i_avs_address, `OFS_ENABLE_SET))
         begin
            // a zero leaves the enable as it is
            set_pulse = field_wr & field_allow;
         end
         if (reg_hit(i_avs_address, `OFS_ENABLE_CLEAR))
         begin
            // each one in an allowed field disables its error interrupt, zeros do nothing
            clr_pulse = field_wr & field_allow;
         end
         if (reg_hit(i_avs_address, `OFS_ERR_STATUS))
         begin
            // flags are write-one-to-clear
            status_clr = field_wr;
         end
      end
   end

   // ======================================================
   // one cell per error source
   genvar gi;
   generate
      for (gi = 0; gi < `ERR_COUNT; gi = gi + 1)
      begin : g_cell
         error_enable_cell u_cell
         (
            .i_sys_clk      (i_sys_clk),
            .i_rst_n        (i_rst_n),
            .i_set_enable   (set_pulse[gi]),
            .i_clear_enable (clr_pulse[gi]),
            .i_event        (i_error_event[gi]),
            .i_status_clear (status_clr[gi]),
            .o_enable       (enable_w[gi]),
            .o_status       (status_w[gi])
         );
      end
   endgenerate

   // ======================================================
   // read multiplexer
   always_comb
   begin
      rd_word = `RST_RDATA;
      // unmapped addresses answer with zero
      if (reg_hit(i_avs_address, `OFS_ENABLE_SET))
      begin
         rd_word = err_word(enable_w);
      end
      else if (reg_hit(i_avs_address, `OFS_ENABLE_CLEAR))
      begin
         // reads show the live enables, one while enabled
         rd_word = err_word(enable_w);
      end
      else if (reg_hit(i_avs_address, `OFS_MODE_CTRL))
      begin
         rd_word[`MODE_LIN_BIT] = s_q.lin_mode;
      end
      else if (reg_hit(i_avs_address, `OFS_ERR_STATUS))
      begin
         rd_word = err_word(status_w);
      end
      else if (reg_hit(i_avs_address, `OFS_ERR_MASK))
      begin
         rd_word = err_word(s_q.mask);
      end
   end

   // ======================================================
   // slave next state
   always_comb
   begin
      s_d = s_q;
      case (s_q.st)
         BUS_IDLE:
         begin
            // a request seen here is answered at the next edge
            if (i_avs_read || i_avs_write)
            begin
               s_d.st       = BUS_ACK;
               s_d.wait_req = 1'b0;
               if (i_avs_read)
               begin
                  s_d.rdata = rd_word;
               end
            end
         end
         BUS_ACK:
         begin
            // the master releases here; stall again for the next one
            s_d.st       = BUS_IDLE;
            s_d.wait_req = 1'b1;
            s_d.rdata    = `RST_RDATA;
         end
         default:
         begin
            s_d.st       = BUS_IDLE;
            s_d.wait_req = 1'b1;
         end
      endcase

      // local registers written at the committing edge
      if (wr_commit && reg_hit(i_avs_address, `OFS_MODE_CTRL) && i_avs_byteenable[0])
      begin
         s_d.lin_mode = i_avs_writedata[`MODE_LIN_BIT];
      end
      if (wr_commit && reg_hit(i_avs_address, `OFS_ERR_MASK))
      begin
         // mask is a plain register, not write-one style
         // only lane 3 carries the mask bits, other lanes leave it alone
         s_d.mask = (s_q.mask & ~{8{i_avs_byteenable[3]}}) | field_wr;
      end

      // interrupt level follows unmasked flags one cycle later
      s_d.irq = |(status_w & s_q.mask);
   end

   // ======================================================
   // slave state register
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_q.st       <= BUS_IDLE;
         s_q.wait_req <= 1'b1;
         s_q.rdata    <= `RST_RDATA;
         s_q.lin_mode <= `RST_LIN_MODE;
         s_q.mask     <= `RST_MASK;
         s_q.irq      <= 1'b0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ======================================================
   // outputs, all straight from flip-flops
   assign o_avs_readdata    = s_q.rdata;
   assign o_avs_waitrequest = s_q.wait_req;
   assign o_error_enable    = enable_w;
   assign o_lin_mode        = s_q.lin_mode;
   assign o_irq             = s_q.irq;

endmodule : lin_error_interrupt_enable_clear

// ==== dv/lin_err_enable_properties.sv ====
// concurrent checks on the ports of the error enable set/clear block
`timescale 1ns/1ps
module lin_err_enable_properties
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   input  wire logic [7:0]  i_error_event,
   input  wire logic [31:0] o_avs_readdata,
   input  wire logic        o_avs_waitrequest,
   input  wire logic [7:0]  o_error_enable,
   input  wire logic        o_lin_mode,
   input  wire logic        o_irq
);
   // =====================================================
   // one clock domain, reset silences every check
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] gate;  // lin-only fields writable only in lin mode
   logic       acc;   // write completes at this edge
   assign gate = o_lin_mode ? 8'hff : 8'h07;
   assign acc  = !o_avs_waitrequest && i_avs_write;
   // =====================================================
   // bus handshake
   chk_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("request not answered next cycle");
   chk_idle_rdata: assert property (o_avs_waitrequest |-> o_avs_readdata == 32'h0)
      else $error("read data not zero while stalled");
   // =====================================================
   // enable and mode register behaviour
   chk_clr_readback: assert property (!o_avs_waitrequest
      && $past(i_avs_read && i_avs_address == 8'h04)
      |-> o_avs_readdata == {$past(o_error_enable), 24'h0})
      else $error("clear register read value wrong");
   chk_clr_write: assert property (acc && i_avs_address == 8'h04
      && i_avs_byteenable[3] |=> o_error_enable ==
      ($past(o_error_enable) & ~($past(i_avs_writedata[31:24]) & $past(gate))))
      else $error("clear write gave wrong enables");
   chk_set_write: assert property (acc && i_avs_address == 8'h00
      && i_avs_byteenable[3] |=> o_error_enable ==
      ($past(o_error_enable) | ($past(i_avs_writedata[31:24]) & $past(gate))))
      else $error("set write gave wrong enables");
   chk_enable_hold: assert property (!acc |=> $stable(o_error_enable))
      else $error("enables changed without a write");
   chk_mode_hold: assert property (!(acc && i_avs_address == 8'h08)
      |=> $stable(o_lin_mode)) else $error("mode changed without a write");
endmodule : lin_err_enable_properties

// ==== dv/lin_error_interrupt_enable_clear_tb.sv ====
// self-checking bench for the error enable set/clear block
`timescale 1ns/1ps
module lin_error_interrupt_enable_clear_tb;
   import lin_err_pkg::*;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, irq, lin, wait_req;
   logic [7:0]  adr = 0, ev = 0, en;          // bus address, event pulses, enables
   logic [3:0]  be = 0;
   logic [31:0] wd = 0, rdat, got, seed = 32'hfabe;
   int n_fail = 0, n_compared = 0, cyc = 0;
   logic [7:0] m_en = 0, m_st = 0, m_mask = 0;  // behavioural model state
   logic       m_lin = 0;
   always #2.5 clk = ~clk;
   lin_error_interrupt_enable_clear u_lin_error_interrupt_enable_clear (.i_sys_clk(clk),
      .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
      .i_avs_writedata(wd), .i_avs_byteenable(be), .i_error_event(ev), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wait_req), .o_error_enable(en), .o_lin_mode(lin), .o_irq(irq));
   // =====================================================
   // helpers: lfsr, compare, verdict
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop;
      if (n_fail == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop
   // hang guard: the whole run needs far fewer cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   // =====================================================
   // avalon transfer: hold until waitrequest sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      logic [7:0] g;
      g = m_lin ? 8'hff : 8'h07;  // lin-only fields gated by mode
      @(posedge clk);
      rd <= !w; wr <= w; adr <= a; wd <= d; be <= b;
      do @(posedge clk); while (wait_req !== 1'b0);
      got = rdat;
      rd <= 0; wr <= 0;
      if (w && b[3] && a == 8'h00) m_en = m_en | (d[31:24] & g);
      if (w && b[3] && a == 8'h04) m_en = m_en & ~(d[31:24] & g);
      if (w && b[0] && a == 8'h08) m_lin = d[0];
      if (w && b[3] && a == 8'h0c) m_st = m_st & ~d[31:24];
      if (w && b[3] && a == 8'h10) m_mask = d[31:24];
   endtask : bus
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      bus(0, a, 32'h0, 4'hf);
      chk(got, exp);
   endtask : rchk
   task automatic pulse(input logic [7:0] e);
      @(posedge clk) ev <= e;
      @(posedge clk) ev <= 0;
      m_st = m_st | (e & m_en);
      repeat (3) @(posedge clk);
      chk(irq, |(m_st & m_mask));
   endtask : pulse
   // =====================================================
   // main sequence
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1;
      // first edge after release still shows the reset values
      @(posedge clk);
      chk(wait_req, 1'b1);
      chk(rdat, 32'h0);
      chk({irq, lin}, 2'b00);
      rchk(8'h04, 32'h0);
      bus(1, 8'h00, 32'hff00_0000, 4'hf);                   // sci mode: low three only
      bus(1, 8'h04, 32'hf8ff_c000, 4'hf);                   // lin-only clears ignored
      rchk(8'h04, {m_en, 24'h0});
      bus(1, 8'h08, 32'h1, 4'hf);
      for (int i = 24; i < 32; i++)
      begin
         bus(1, 8'h00, 32'hff00_0000, 4'hf);
         bus(1, 8'h04, 32'h1 << i, 4'hf);                   // whole word written
         rchk(8'h04, {m_en, 24'h0});
         chk(en, m_en);
      end
      bus(1, 8'h04, 32'h00ff_ffff, 4'hf);
      rchk(8'h04, {m_en, 24'h0});
      // sci mode with lin-only enables set: only the low three clear
      bus(1, 8'h08, 32'h0, 4'hf);
      bus(1, 8'h04, 32'hff00_0000, 4'hf);
      rchk(8'h04, {m_en, 24'h0});
      chk(lin, m_lin);
      for (int i = 0; i < 40; i++)
      begin
         seed = lfsr(seed);
         bus(1, 8'h08, {31'h0, seed[5]}, 4'hf);
         bus(1, {5'h0, seed[4], 2'h0}, seed, {seed[6], 3'h7});
         rchk({5'h0, seed[7], 2'h0}, {m_en, 24'h0});
         rchk(8'h08, {31'h0, m_lin});
         chk(lin, m_lin);
      end
      rchk(8'h40, 32'h0);
      // interrupt: raise, mask, clear, then a disabled source
      bus(1, 8'h08, 32'h1, 4'hf);
      bus(1, 8'h00, 32'hff00_0000, 4'hf);
      pulse(8'h02);
      bus(1, 8'h10, 32'h0300_0000, 4'hf);
      pulse(8'h01);
      rchk(8'h0c, {m_st, 24'h0});
      bus(1, 8'h0c, 32'h0300_0000, 4'hf);
      bus(1, 8'h04, 32'h0100_0000, 4'hf);
      pulse(8'h01);
      rchk(8'h0c, {m_st, 24'h0});
      report_and_stop();
   end
endmodule : lin_error_interrupt_enable_clear_tb
// checker watches the top module ports
bind lin_error_interrupt_enable_clear lin_err_enable_properties u_props (
   .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .i_error_event(i_error_event),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_error_enable(o_error_enable), .o_lin_mode(o_lin_mode), .o_irq(o_irq));
